// ==== design/ex21_pkg.sv ====
// What this block does
// - Command feature off: bytes sent unaltered
// - Empty transmit FIFO: send SYN 16 hex
// - Byte 80 hex starts four-byte command
// - Byte two sets request-to-send level
// - Byte three is pattern, no parity
// - Byte four counts repeats; zero repeats until new host data
// - Zero count sends pattern at least thrice
// - Receive sync character programmable, default 16
// - Single or double SYN synchronisation select
// - Pass all characters; flag sync detection
// - Sync event after first or second SYN
// - No stripping unless steady-state detect enabled
package ex21_pkg;
  // Transmit idle fill character
  localparam logic [7:0] EX21_IDLE_SYN = 8'h16;
  // In-band command lead-in byte
  localparam logic [7:0] EX21_CMD_LEAD = 8'h80;
  // Request-to-send argument codes
  localparam logic [7:0] EX21_RTS_OFF = 8'h00;
  localparam logic [7:0] EX21_RTS_ON = 8'h01;
  // Default receive sync character after init
  localparam logic [7:0] EX21_SYNC_RESET = 8'h16;
  // Minimum copies for an open-ended pattern
  localparam logic [7:0] EX21_MIN_REPEAT = 8'h03;
  // Bits per character on the line
  localparam int EX21_CHAR_BITS = 8;

  // Transmit parser states, Gray coded along the command path
  typedef enum logic [2:0] {
    EX21_TX_DATA = 3'b000,
    EX21_TX_ARG_RTS = 3'b001,
    EX21_TX_ARG_PAT = 3'b011,
    EX21_TX_ARG_CNT = 3'b010,
    EX21_TX_PATTERN = 3'b110
  } ex21_tx_state_type;
endpackage : ex21_pkg

// ==== design/ex21_skid_buf.sv ====
`timescale 1ns/10ps
// Two-entry buffer with valid/ready on both sides
module ex21_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] slot0; // Head entry, feeds the output
  logic [WIDTH-1:0] slot1; // Second entry
  logic [1:0] count; // Entries held
  logic push;
  logic pop;

  // Ready only while a slot is free, so the source really stalls
  assign in_ready_o = (count != 2'd2);
  assign out_valid_o = (count != 2'd0);
  assign out_data_o = slot0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Occupancy
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= 2'd0;
    end else if (push && !pop) begin
      count <= count + 2'd1;
    end else if (pop && !push) begin
      count <= count - 2'd1;
    end
  end

  // Data slots; head shifts forward on a pop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slot0 <= '0;
      slot1 <= '0;
    end else begin
      if (pop) begin
        slot0 <= (count == 2'd2) ? slot1 : in_data_i;
      end else if (push && count == 2'd0) begin
        slot0 <= in_data_i;
      end
      if (push && ((count == 2'd1 && !pop) || (count == 2'd2))) begin
        slot1 <= in_data_i;
      end
    end
  end
endmodule : ex21_skid_buf

// ==== design/ex21_channel.sv ====
`timescale 1ns/10ps
// One channel of the extended character-synchronous mode
module ex21_channel
  import ex21_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Configuration bits
  input wire logic inband_tx_command_i, // Command interpretation on
  input wire logic single_sync_select_i, // Sync on one SYN
  input wire logic steady_state_detect_en_i, // Enables strip options
  input wire logic strip_sync_en_i, // Strip SYN after sync
  input wire logic special_char_detect_en_i, // Accepted, no effect here
  input wire logic channel_init_i, // Pulse: channel initialisation
  input wire logic sync_char_we_i, // Pulse: write sync character
  input wire logic [7:0] sync_char_i, // New sync character
  output logic [7:0] sync_char_o, // Current sync character
  // Transmit data from host FIFO
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i,
  // Transmit character to serialiser
  output logic line_tx_valid_o,
  input wire logic line_tx_ready_i,
  output logic [7:0] line_tx_data_o,
  output logic rts_b_o, // Request-to-send, active low
  // Receive character from deserialiser
  input wire logic line_rx_valid_i,
  input wire logic [7:0] line_rx_data_i,
  // Receive data to host
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_overrun_o, // Pulse: char lost, host stalled
  output logic sync_detect_o, // Pulse: synchronisation reached
  output logic in_sync_o // Level: character sync held
);
  ex21_tx_state_type state; // Transmit parser state
  logic [7:0] pat_char; // Pattern character
  logic [7:0] pat_count; // Remaining copies, zero means open
  logic pat_open; // Open-ended repeat
  logic [7:0] pat_sent; // Copies sent, saturating at minimum
  logic [7:0] tx_char; // Character chosen for the line
  logic tx_take_data; // Data byte goes to the line now
  logic line_fire; // Serialiser accepts a character
  logic [7:0] sync_char; // Programmed receive sync value
  logic sync_seen; // First SYN seen in double mode
  logic rx_strip; // Drop this received character
  logic rx_push;
  logic rx_in_ready;

  assign line_fire = line_tx_valid_o && line_tx_ready_i;
  // Serialiser always has something: data, pattern or SYN fill
  assign line_tx_valid_o = 1'b1;

  // Pattern may end early only after minimum copies and new data
  logic pat_done;
  always_comb begin
    pat_done = 1'b0;
    if (pat_open) begin
      pat_done = tx_valid_i && (pat_sent >= EX21_MIN_REPEAT);
    end else begin
      pat_done = (pat_count == 8'h00);
    end
  end

  // Line character selection
  always_comb begin
    tx_take_data = 1'b0;
    tx_char = EX21_IDLE_SYN;
    if (state == EX21_TX_PATTERN && !pat_done) begin
      tx_char = pat_char;
    end else if (state == EX21_TX_DATA && tx_valid_i) begin
      if (!(inband_tx_command_i && tx_data_i == EX21_CMD_LEAD)) begin
        tx_take_data = 1'b1;
        tx_char = tx_data_i;
      end
    end
  end

  // Command bytes are consumed without a line slot; data waits for one
  always_comb begin
    tx_ready_o = 1'b0;
    case (state)
      EX21_TX_DATA: tx_ready_o = tx_take_data ? line_fire : 1'b1;
      EX21_TX_ARG_RTS: tx_ready_o = 1'b1;
      EX21_TX_ARG_PAT: tx_ready_o = 1'b1;
      EX21_TX_ARG_CNT: tx_ready_o = 1'b1;
      EX21_TX_PATTERN: tx_ready_o = 1'b0;
      default: tx_ready_o = 1'b0;
    endcase
  end

  // Transmit parser
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= EX21_TX_DATA;
    end else begin
      case (state)
        EX21_TX_DATA: begin
          if (tx_valid_i && inband_tx_command_i && tx_data_i == EX21_CMD_LEAD) begin
            state <= EX21_TX_ARG_RTS;
          end
        end
        EX21_TX_ARG_RTS: if (tx_valid_i) state <= EX21_TX_ARG_PAT;
        EX21_TX_ARG_PAT: if (tx_valid_i) state <= EX21_TX_ARG_CNT;
        EX21_TX_ARG_CNT: if (tx_valid_i) state <= EX21_TX_PATTERN;
        EX21_TX_PATTERN: if (pat_done) state <= EX21_TX_DATA;
        default: state <= EX21_TX_DATA;
      endcase
    end
  end

  // Request-to-send from command byte two; reserved codes leave it alone
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rts_b_o <= 1'b1;
    end else if (state == EX21_TX_ARG_RTS && tx_valid_i) begin
      if (tx_data_i == EX21_RTS_OFF) begin
        rts_b_o <= 1'b1;
      end else if (tx_data_i == EX21_RTS_ON) begin
        rts_b_o <= 1'b0;
      end
    end
  end

  // Pattern character, count and sent tally
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pat_char <= 8'h00;
      pat_count <= 8'h00;
      pat_open <= 1'b0;
      pat_sent <= 8'h00;
    end else begin
      if (state == EX21_TX_ARG_PAT && tx_valid_i) begin
        pat_char <= tx_data_i;
      end
      if (state == EX21_TX_ARG_CNT && tx_valid_i) begin
        pat_count <= tx_data_i;
        pat_open <= (tx_data_i == 8'h00);
        pat_sent <= 8'h00;
      end else if (state == EX21_TX_PATTERN && !pat_done && line_fire) begin
        if (!pat_open) begin
          pat_count <= pat_count - 8'h01;
        end
        if (pat_sent < EX21_MIN_REPEAT) begin
          pat_sent <= pat_sent + 8'h01;
        end
      end
    end
  end

  // Line data register, reloaded whenever the serialiser takes one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_tx_data_o <= EX21_IDLE_SYN;
    end else if (line_fire) begin
      line_tx_data_o <= tx_char;
    end
  end

  // Sync character: loaded at init, host may overwrite later
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_char <= EX21_SYNC_RESET;
    end else if (channel_init_i) begin
      sync_char <= EX21_SYNC_RESET;
    end else if (sync_char_we_i) begin
      sync_char <= sync_char_i;
    end
  end
  assign sync_char_o = sync_char;

  // Sync hunt: single or two consecutive SYN characters
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_seen <= 1'b0;
      in_sync_o <= 1'b0;
      sync_detect_o <= 1'b0;
    end else begin
      sync_detect_o <= 1'b0;
      if (channel_init_i) begin
        sync_seen <= 1'b0;
        in_sync_o <= 1'b0;
      end else if (line_rx_valid_i && !in_sync_o) begin
        if (line_rx_data_i == sync_char) begin
          if (single_sync_select_i || sync_seen) begin
            in_sync_o <= 1'b1;
            sync_detect_o <= 1'b1;
          end
          sync_seen <= 1'b1;
        end else begin
          sync_seen <= 1'b0;
        end
      end
    end
  end

  // Strip SYN only after sync and only with steady-state detect on
  assign rx_strip = steady_state_detect_en_i && strip_sync_en_i && in_sync_o
                    && (line_rx_data_i == sync_char);
  // Everything else passes, before and after sync
  assign rx_push = line_rx_valid_i && !rx_strip;

  // Lost character when host stalls the buffer full
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_overrun_o <= 1'b0;
    end else begin
      rx_overrun_o <= rx_push && !rx_in_ready;
    end
  end

  // Receive buffer toward the host
  ex21_skid_buf #(
    .WIDTH(EX21_CHAR_BITS)
  ) u_rx_buf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_in_ready),
    .in_data_i(line_rx_data_i),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );
endmodule : ex21_channel

// ==== bench/ex21_channel_chk.sv ====
`timescale 1ns/10ps
// Port-level watch on one channel
module ex21_channel_chk
  import ex21_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic inband_tx_command_i,
  input wire logic single_sync_select_i,
  input wire logic steady_state_detect_en_i,
  input wire logic channel_init_i,
  input wire logic [7:0] sync_char_o,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic [7:0] tx_data_i,
  input wire logic line_tx_ready_i,
  input wire logic [7:0] line_tx_data_o,
  input wire logic rts_b_o,
  input wire logic line_rx_valid_i,
  input wire logic [7:0] line_rx_data_i,
  input wire logic rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic sync_detect_o,
  input wire logic in_sync_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [1:0] pos; // Command byte count, 0 between commands
  logic hit; // Previous char matched sync
  wire acc = tx_valid_i && tx_ready_o; // Byte taken from host
  wire sm = line_rx_valid_i && line_rx_data_i == sync_char_o; // Sync char arrives
  wire arg = acc && pos == 2'd1; // Request-to-send argument taken
  // Follow the host stream through each four-byte command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos <= 2'd0;
    end else if (acc && (pos != 2'd0 || (inband_tx_command_i && tx_data_i == EX21_CMD_LEAD))) begin
      pos <= pos + 2'd1;
    end
  end
  // Hunt history; init restarts it as the channel does
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hit <= 1'b0;
    end else if (channel_init_i) begin
      hit <= 1'b0;
    end else if (line_rx_valid_i) begin
      hit <= sm;
    end
  end
  property p_on; arg && tx_data_i == EX21_RTS_ON |=> !rts_b_o; endproperty
  a_on: assert property (p_on) else $error("rts not active");
  property p_off; arg && tx_data_i == EX21_RTS_OFF |=> rts_b_o; endproperty
  a_off: assert property (p_off) else $error("rts not idle");
  property p_rsvd; arg && tx_data_i > EX21_RTS_ON |=> $stable(rts_b_o); endproperty
  a_rsvd: assert property (p_rsvd) else $error("rts moved");
  property p_pass; acc && !inband_tx_command_i |-> line_tx_ready_i ##1 line_tx_data_o == $past(tx_data_i); endproperty
  a_pass: assert property (p_pass) else $error("byte altered");
  property p_one; sm && single_sync_select_i && !in_sync_o |=> sync_detect_o && in_sync_o; endproperty
  a_one: assert property (p_one) else $error("no sync event");
  property p_two; sm && hit && !single_sync_select_i && !in_sync_o |=> sync_detect_o ##1 !sync_detect_o; endproperty
  a_two: assert property (p_two) else $error("bad sync event");
  property p_rx; line_rx_valid_i && !rx_valid_o && !steady_state_detect_en_i |=> rx_data_o == $past(line_rx_data_i); endproperty
  a_rx: assert property (p_rx) else $error("char not passed");
  property p_init; channel_init_i |=> sync_char_o == EX21_SYNC_RESET && !in_sync_o; endproperty
  a_init: assert property (p_init) else $error("init failed");
  c_cmd: cover property (acc && pos == 2'd3);
  c_open: cover property (acc && pos == 2'd3 && tx_data_i == 8'h00);
  c_sync: cover property (sync_detect_o);
endmodule : ex21_channel_chk

// ==== bench/ex21_serial_model.sv ====
`timescale 1ns/10ps
// Serialiser: takes one character per character time
module ex21_serial_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic fast_i, // Every cycle, else every fourth
  output logic line_tx_ready_o
);
  logic [1:0] div; // Character-time divider
  // Slow pace lets the idle fill show between data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div <= 2'd0;
      line_tx_ready_o <= 1'b0;
    end else begin
      div <= div + 2'd1;
      line_tx_ready_o <= fast_i || div == 2'd3;
    end
  end
endmodule : ex21_serial_model

// ==== bench/ex21_channel_tb.sv ====
`timescale 1ns/10ps
// Self-checking bench: host stream, serialiser, receiver
module ex21_channel_tb;
  import ex21_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, fast = 1'b0, rm = 1'b1;
  logic inband_tx_command_i = 1'b0, single_sync_select_i = 1'b0, steady_state_detect_en_i = 1'b0;
  logic strip_sync_en_i = 1'b1, special_char_detect_en_i = 1'b1; // Set; strip needs steady-state detect too, special char inert
  logic channel_init_i = 1'b0, sync_char_we_i = 1'b0, tx_valid_i = 1'b0, line_rx_valid_i = 1'b0, rx_ready_i = 1'b1;
  logic [7:0] sync_char_i = 8'h00, tx_data_i = 8'h00, line_rx_data_i = 8'h00;
  logic [7:0] sync_char_o, line_tx_data_o, rx_data_o;
  logic tx_ready_o, line_tx_valid_o, line_tx_ready_i, rts_b_o, rx_valid_o, rx_overrun_o, sync_detect_o, in_sync_o;
  logic [7:0] lf = 8'h2C; // LFSR, seeded with 44
  logic [7:0] extra = EX21_IDLE_SYN; // Open pattern copies past three
  logic [7:0] tq[$], rq[$]; // Line and host chars still due
  logic [7:0] rc[5] = '{8'h01, 8'h00, 8'h07, 8'h01, 8'h00};
  logic [7:0] pc[5] = '{8'hA5, 8'hFF, 8'h3C, 8'h80, 8'h5A};
  int nc[5] = '{4, 0, 2, 1, 0};
  logic [7:0] rb[12] = '{8'h31, 8'h7E, 8'h32, 8'h7E, 8'h7E, 8'h33, 8'h41, 8'h16, 8'h42, 8'h16, 8'h43, 8'h44};
  int fail_count = 0, checks = 0, syncs = 0, ovr = 0;
  always #12.5 clk_i = ~clk_i;
  ex21_channel dut_u (.*);
  ex21_serial_model line_u (.clk_i, .rst_b_i, .fast_i(fast), .line_tx_ready_o(line_tx_ready_i));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  // One host byte; valid stays up so bytes can follow back to back
  task automatic put(input logic [7:0] b);
    tx_valid_i = 1'b1;
    tx_data_i = b;
    #1;
    for (int n = 0; n < 400 && tx_ready_o !== 1'b1; n++) begin
      @(negedge clk_i);
      #1;
    end
    // A byte never taken is a hang, counted as a failure
    if (tx_ready_o !== 1'b1) fail_count++;
    @(negedge clk_i);
  endtask : put
  task automatic cmd(input logic [7:0] r, input logic [7:0] p, input int c);
    put(EX21_CMD_LEAD);
    put(r);
    put(p);
    put(8'(c));
    repeat ((c == 0) ? 3 : c) tq.push_back(p);
    extra = (c == 0) ? p : EX21_IDLE_SYN;
    // Slow pass lets an open pattern run on with the host idle
    if (c == 0 && !fast) begin
      tx_valid_i = 1'b0;
      repeat (24) @(negedge clk_i);
      cmp(line_tx_data_o, p);
    end
  endtask : cmd
  // Random bytes clear of lead and fill codes, then idle
  task automatic data(input int k);
    repeat (k) begin
      lf = nxt(lf);
      tq.push_back((lf & 8'h6F) | 8'h20);
      put((lf & 8'h6F) | 8'h20);
    end
    tx_valid_i = 1'b0;
    repeat (40) @(negedge clk_i);
    cmp(8'(tq.size()), 8'h00);
    cmp(line_tx_data_o, EX21_IDLE_SYN);
    cmp({7'h00, line_tx_valid_o}, 8'h01);
  endtask : data
  task automatic rcv(input logic [7:0] b, input bit keep);
    line_rx_valid_i = 1'b1;
    line_rx_data_i = b;
    if (keep) rq.push_back(b);
    @(negedge clk_i);
  endtask : rcv
  task automatic setsync(input logic [7:0] s);
    channel_init_i = 1'b1;
    @(negedge clk_i);
    cmp(sync_char_o, EX21_SYNC_RESET);
    channel_init_i = 1'b0;
    sync_char_we_i = 1'b1;
    sync_char_i = s;
    @(negedge clk_i);
    sync_char_we_i = 1'b0;
    cmp(sync_char_o, s);
  endtask : setsync
  // Line takes: fill and trailing open-pattern copies are skipped
  always @(posedge clk_i) begin
    if (rst_b_i && line_tx_ready_i && line_tx_data_o !== EX21_IDLE_SYN) begin
      if (line_tx_data_o !== extra || (tq.size() > 0 && tq[0] === extra))
        cmp(line_tx_data_o, (tq.size() > 0) ? tq.pop_front() : ~line_tx_data_o);
    end
    if (rst_b_i && rx_valid_o && rx_ready_i) cmp(rx_data_o, (rq.size() > 0) ? rq.pop_front() : ~rx_data_o);
    if (rst_b_i && sync_detect_o) syncs++;
    if (rst_b_i && rx_overrun_o) ovr++;
  end
  initial begin
    repeat (12) @(negedge clk_i);
    rst_b_i = 1'b1;
    cmp(sync_char_o, EX21_SYNC_RESET);
    tq.push_back(EX21_CMD_LEAD);
    put(EX21_CMD_LEAD);
    data(5);
    inband_tx_command_i = 1'b1;
    for (int i = 0; i < 5; i++) begin
      fast = i[0];
      cmd(rc[i], pc[i], nc[i]);
      rm = (rc[i] == 8'h00) ? 1'b1 : (rc[i] == 8'h01) ? 1'b0 : rm;
      data(3);
      cmp({7'h00, rts_b_o}, {7'h00, rm});
    end
    for (int m = 0; m < 2; m++) begin
      single_sync_select_i = m[0];
      setsync(m ? EX21_SYNC_RESET : 8'h7E);
      for (int i = 0; i < 6; i++) rcv(rb[m * 6 + i], 1'b1);
      line_rx_valid_i = 1'b0;
      repeat (4) @(negedge clk_i);
      cmp(8'(syncs), 8'(m + 1));
    end
    rx_ready_i = 1'b0;
    rcv(8'h51, 1'b1);
    rcv(8'h52, 1'b1);
    rcv(8'h53, 1'b0);
    line_rx_valid_i = 1'b0;
    repeat (2) @(negedge clk_i);
    cmp(8'(ovr), 8'h01);
    rx_ready_i = 1'b1;
    repeat (6) @(negedge clk_i);
    // Still in sync on 16 hex: with both enables the SYN is dropped
    steady_state_detect_en_i = 1'b1;
    rcv(EX21_SYNC_RESET, 1'b0);
    rcv(8'h61, 1'b1);
    line_rx_valid_i = 1'b0;
    steady_state_detect_en_i = 1'b0;
    repeat (4) @(negedge clk_i);
    cmp(8'(rq.size()), 8'h00);
    end_of_test();
  end
  // Watchdog well past the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end
endmodule : ex21_channel_tb
bind ex21_channel ex21_channel_chk chk_u (.*);
